// File: design/pcss_pkg.sv
// Shared constants and types for the 16-bit card socket cycle engine
package pcss_pkg;

  // Core clock
  localparam int CLK_NS = 40;

  // Cycle timing, in ns as specified
  localparam int SETUP_NS      = 100;
  localparam int STROBE_NS     = 300;
  localparam int HOLD_NS       = 40;
  localparam int CARD_RESET_NS = 10000;

  // Cycle counts, rounded up to whole clocks
  localparam logic [7:0] SETUP_CYC  = 8'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC   = 8'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RESET_CYC  = 8'((CARD_RESET_NS + CLK_NS - 1) / CLK_NS);

  // Bus widths
  localparam int DATA_W = 16;
  localparam int SYNC_W = DATA_W + 5;

  // Host request kinds
  typedef enum logic [2:0] {
    K_MEM_RD,
    K_MEM_WR,
    K_ATT_RD,
    K_ATT_WR,
    K_IO_RD,
    K_IO_WR
  } pcss_kind_t;

  // DMA direction: read moves host to card, write moves card to host
  localparam logic DMA_DIR_READ  = 1'b0;
  localparam logic DMA_DIR_WRITE = 1'b1;

  // Voltage sense classes, coded as {sense_b, sense_a}
  typedef enum logic [1:0] {
    VOLT_CLASS_0,
    VOLT_CLASS_1,
    VOLT_CLASS_2,
    VOLT_CLASS_3
  } pcss_volt_t;

endpackage : pcss_pkg

// File: design/pcss_sync.sv
// Two-stage synchroniser for asynchronous card inputs
`timescale 1ns/1ps
module pcss_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } pcss_sync_regs_t;

  pcss_sync_regs_t sync_r;
  pcss_sync_regs_t sync_nxt;

  // Only the second stage is read outside this module
  always_comb begin
    sync_nxt.meta = d;
    sync_nxt.held = sync_r.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign q = sync_r.held;

endmodule : pcss_sync

// File: design/pcss_socket.sv
// Host-side signalling engine for one 16-bit card socket
// Overview of operation
// - Memory read pulses output-enable strobe low
// - Output-enable marks terminal count on DMA write
// - Write-enable strobe clocks memory write data
// - Write-enable marks terminal count on DMA read
// - Ready only in memory mode, else interrupt
// - Attribute select high on common memory
// - Attribute select picks attribute or I/O space
// - Attribute select acts as DMA acknowledge
// - Card reset output forces hard reset
// - Both sense lines decide card voltage
// - Wait from card stretches current strobe
// - Write-protect pin reports card switch in memory mode only
// - I/O read and write strobes pulse low
`timescale 1ns/1ps
module pcss_socket
  import pcss_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Socket configuration
  input  wire logic              mem_only_mode,
  input  wire logic              dma_en,
  input  wire logic              card_reset_req,
  // Host request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  pcss_kind_t             req_kind,
  input  wire logic [DATA_W-1:0] req_wdata,
  // Host response
  output logic                   resp_valid,
  output logic      [DATA_W-1:0] resp_rdata,
  // DMA channel
  input  wire logic              dma_dir,
  input  wire logic              dma_last,
  input  wire logic [DATA_W-1:0] dma_wdata,
  output logic                   dma_done,
  // Card status to host
  output logic                   card_ready,
  output logic                   card_irq,
  output logic                   write_protect,
  output logic                   io_wide,
  output logic                   dma_pending,
  output pcss_volt_t             volt_class,
  output logic                   cycle_busy,
  // Card strobes
  output logic                   mem_read_strobe_n,
  output logic                   mem_write_strobe_n,
  output logic                   io_read_strobe_n,
  output logic                   io_write_strobe_n,
  output logic                   attr_select_n,
  output logic                   card_reset,
  // Card data bus
  input  wire logic [DATA_W-1:0] card_data_i,
  output logic      [DATA_W-1:0] card_data_o,
  output logic                   card_data_oe,
  // Card status pins
  input  wire logic              card_wait_n,
  input  wire logic              card_irq_n,
  input  wire logic              io_port_wide_ack_n,
  input  wire logic              voltage_sense_a,
  input  wire logic              voltage_sense_b
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_RESET
  } pcss_state_t;

  typedef struct packed {
    pcss_state_t       st;
    logic [7:0]        cnt;
    pcss_kind_t        kind;
    logic              dma;
    logic              dma_wr;
    logic              tc;
    logic              oe_n;
    logic              we_n;
    logic              io_read_strobe_n_n;
    logic              io_write_strobe_n_n;
    logic              reg_n;
    logic              card_reset;
    logic              data_oe;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              done;
    logic              dma_done;
    logic              ready;
    logic              irq;
    logic              wprot;
    logic              wide;
    logic              dreq;
    pcss_volt_t        volt;
  } pcss_regs_t;

  // Card held in reset after controller reset
  localparam pcss_regs_t RST_VAL = '{
    st: ST_RESET, cnt: RESET_CYC - 8'h01, kind: K_MEM_RD, dma: 1'b0,
    dma_wr: 1'b0, tc: 1'b0, oe_n: 1'b1, we_n: 1'b1, io_read_strobe_n_n: 1'b1,
    io_write_strobe_n_n: 1'b1, reg_n: 1'b1, card_reset: 1'b1, data_oe: 1'b0,
    wdata: '0, rdata: '0, done: 1'b0, dma_done: 1'b0, ready: 1'b0,
    irq: 1'b0, wprot: 1'b0, wide: 1'b0, dreq: 1'b0, volt: VOLT_CLASS_0};

  pcss_regs_t        s_r;
  pcss_regs_t        s_nxt;
  logic [SYNC_W-1:0] sync_q;
  logic [DATA_W-1:0] data_s;
  logic              wait_n_s;
  logic              irq_n_s;
  logic              wp_s;
  logic              vs_a_s;
  logic              vs_b_s;
  logic              wr_blocked;
  logic              dma_start;
  logic              is_write;

  pcss_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({card_data_i, card_wait_n, card_irq_n, io_port_wide_ack_n,
           voltage_sense_a, voltage_sense_b}),
    .q   (sync_q)
  );

  assign {data_s, wait_n_s, irq_n_s, wp_s, vs_a_s, vs_b_s} = sync_q;

  // Hold off memory writes while busy
  assign wr_blocked = mem_only_mode && !irq_n_s && (req_kind == K_MEM_WR);
  assign dma_start  = dma_en && wp_s && !card_reset_req;
  assign is_write   = (req_kind == K_MEM_WR) || (req_kind == K_ATT_WR) ||
                      (req_kind == K_IO_WR);
  assign req_ready  = (s_r.st == ST_IDLE) && !card_reset_req && !dma_start &&
                      !wr_blocked;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.done     = 1'b0;
    s_nxt.dma_done = 1'b0;
    // Shared pin split by interface mode
    s_nxt.ready    = mem_only_mode && irq_n_s;
    s_nxt.irq      = !mem_only_mode && !irq_n_s;
    s_nxt.wprot    = mem_only_mode && wp_s;
    s_nxt.wide     = !mem_only_mode && !dma_en && !wp_s;
    s_nxt.dreq     = dma_en && wp_s;
    s_nxt.volt     = pcss_volt_t'({vs_b_s, vs_a_s});
    case (s_r.st)
      ST_IDLE: begin
        if (card_reset_req) begin
          s_nxt.st         = ST_RESET;
          s_nxt.cnt        = RESET_CYC - 8'h01;
          s_nxt.card_reset = 1'b1;
        end else if (dma_start) begin
          s_nxt.st      = ST_SETUP;
          s_nxt.cnt     = SETUP_CYC - 8'h01;
          s_nxt.dma     = 1'b1;
          s_nxt.dma_wr  = dma_dir;
          s_nxt.tc      = dma_last;
          s_nxt.reg_n   = 1'b0;
          s_nxt.wdata   = dma_wdata;
          s_nxt.data_oe = (dma_dir == DMA_DIR_READ);
        end else if (req_valid && req_ready) begin
          s_nxt.st      = ST_SETUP;
          s_nxt.cnt     = SETUP_CYC - 8'h01;
          s_nxt.dma     = 1'b0;
          s_nxt.kind    = req_kind;
          // Common memory keeps attribute select high
          s_nxt.reg_n   = (req_kind == K_MEM_RD) || (req_kind == K_MEM_WR);
          s_nxt.wdata   = req_wdata;
          s_nxt.data_oe = is_write;
        end
      end
      ST_SETUP: begin
        if (s_r.cnt != 8'h00) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else begin
          s_nxt.st  = ST_STROBE;
          s_nxt.cnt = STROBE_CYC - 8'h01;
          if (s_r.dma) begin
            // DMA data moves on I/O strobes
            s_nxt.io_read_strobe_n_n = !(s_r.dma_wr == DMA_DIR_WRITE);
            s_nxt.io_write_strobe_n_n = !(s_r.dma_wr == DMA_DIR_READ);
            s_nxt.oe_n   = !(s_r.tc && s_r.dma_wr == DMA_DIR_WRITE);
            s_nxt.we_n   = !(s_r.tc && s_r.dma_wr == DMA_DIR_READ);
          end else begin
            s_nxt.oe_n   = !(s_r.kind == K_MEM_RD || s_r.kind == K_ATT_RD);
            s_nxt.we_n   = !(s_r.kind == K_MEM_WR || s_r.kind == K_ATT_WR);
            // I/O strobes with attribute select low
            s_nxt.io_read_strobe_n_n = !(s_r.kind == K_IO_RD);
            s_nxt.io_write_strobe_n_n = !(s_r.kind == K_IO_WR);
          end
        end
      end
      ST_STROBE: begin
        if (s_r.cnt != 8'h00) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else if (wait_n_s) begin
          s_nxt.st     = ST_HOLD;
          s_nxt.cnt    = HOLD_CYC - 8'h01;
          s_nxt.oe_n   = 1'b1;
          s_nxt.we_n   = 1'b1;
          s_nxt.io_read_strobe_n_n = 1'b1;
          s_nxt.io_write_strobe_n_n = 1'b1;
          s_nxt.rdata  = data_s;
        end
      end
      ST_HOLD: begin
        if (s_r.cnt != 8'h00) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else begin
          s_nxt.st       = ST_IDLE;
          s_nxt.reg_n    = 1'b1;
          s_nxt.data_oe  = 1'b0;
          s_nxt.done     = 1'b1;
          s_nxt.dma_done = s_r.dma;
          s_nxt.dma      = 1'b0;
          s_nxt.tc       = 1'b0;
        end
      end
      ST_RESET: begin
        if (s_r.cnt != 8'h00) begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end else begin
          s_nxt.st         = ST_IDLE;
          s_nxt.card_reset = 1'b0;
        end
      end
      default: begin
        s_nxt = RST_VAL;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= RST_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign resp_valid         = s_r.done;
  assign resp_rdata         = s_r.rdata;
  assign dma_done           = s_r.dma_done;
  assign card_ready         = s_r.ready;
  assign card_irq           = s_r.irq;
  assign write_protect      = s_r.wprot;
  assign io_wide            = s_r.wide;
  assign dma_pending        = s_r.dreq;
  assign volt_class         = s_r.volt;
  assign cycle_busy         = (s_r.st != ST_IDLE);
  assign mem_read_strobe_n  = s_r.oe_n;
  assign mem_write_strobe_n = s_r.we_n;
  assign io_read_strobe_n   = s_r.io_read_strobe_n_n;
  assign io_write_strobe_n  = s_r.io_write_strobe_n_n;
  assign attr_select_n      = s_r.reg_n;
  assign card_reset         = s_r.card_reset;
  assign card_data_o        = s_r.wdata;
  assign card_data_oe       = s_r.data_oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_strobe_start(pcss_kind_t k);
    s_r.st == ST_SETUP && s_r.cnt == 8'h00 && !s_r.dma && s_r.kind == k;
  endsequence

  sequence seq_dma_tc_start(logic dir);
    s_r.st == ST_SETUP && s_r.cnt == 8'h00 && s_r.dma && s_r.tc &&
      s_r.dma_wr == dir;
  endsequence

  a_mem_read_strobe: assert property (
    seq_strobe_start(K_MEM_RD) |=> !mem_read_strobe_n [*8])
    else $error("memory read strobe not held low for full width");

  a_tc_dma_write: assert property (
    seq_dma_tc_start(DMA_DIR_WRITE) |=> (!mem_read_strobe_n && !io_read_strobe_n) [*8])
    else $error("terminal count missing on DMA write");

  a_mem_write_strobe: assert property (
    seq_strobe_start(K_MEM_WR) |=> (!mem_write_strobe_n && card_data_oe) [*8])
    else $error("memory write strobe not held low for full width");

  a_tc_dma_read: assert property (
    seq_dma_tc_start(DMA_DIR_READ) |=> (!mem_write_strobe_n && !io_write_strobe_n) [*8])
    else $error("terminal count missing on DMA read");

  a_irq_mode_split: assert property (
    mem_only_mode && $stable(mem_only_mode) |=> !card_irq)
    else $error("interrupt reported in memory-only mode");

  a_ready_gate_write: assert property (
    (s_r.st == ST_IDLE && s_nxt.st == ST_SETUP && !s_nxt.dma &&
     s_nxt.kind == K_MEM_WR && mem_only_mode) |-> irq_n_s)
    else $error("memory write started while card busy");

  a_common_attr_high: assert property (
    (!mem_read_strobe_n || !mem_write_strobe_n) && !s_r.dma &&
      (s_r.kind == K_MEM_RD || s_r.kind == K_MEM_WR) |-> attr_select_n)
    else $error("attribute select low during common memory access");

  a_io_attr_low: assert property (
    (!io_read_strobe_n || !io_write_strobe_n) |-> !attr_select_n)
    else $error("I/O strobe without attribute select low");

  a_dma_ack: assert property (
    s_r.dma && s_r.st != ST_IDLE |-> !attr_select_n)
    else $error("DMA cycle without acknowledge");

  a_card_reset_width: assert property (
    $rose(card_reset) |-> card_reset [*8] ##1 (card_reset && cycle_busy))
    else $error("card reset pulse too short");

  a_wait_stretch: assert property (
    (s_r.st == ST_STROBE && s_r.cnt == 8'h00 && !wait_n_s) |=>
      (s_r.st == ST_STROBE && ($stable(mem_read_strobe_n) && $stable(io_read_strobe_n))))
    else $error("cycle completed while card asserts wait");

  a_strobe_exclusive: assert property (
    !(!io_read_strobe_n && !io_write_strobe_n) &&
      !(!io_read_strobe_n && card_data_oe))
    else $error("I/O strobes overlap or bus driven during I/O read");

endmodule : pcss_socket

// File: test/pcss_card_model.sv
// Behavioural 16-bit card facing the socket engine
`timescale 1ns/1ps
module pcss_card_model (
  // Socket side
  input  wire logic        clk,
  input  wire logic        mem_only,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] dout,
  input  wire logic        dout_oe,
  output logic      [15:0] din,
  // Card state set by the bench
  input  wire logic        busy,
  input  wire logic        irq_req,
  input  wire logic [7:0]  wait_len,
  input  wire logic [15:0] rd_word,
  output logic      [15:0] wr_word,
  // Card status pins
  output logic             ready_irq_n,
  output logic             wait_n
);
  logic [7:0] wcnt;
  initial din = 16'h0000;
  initial wcnt = 8'h00;
  assign ready_irq_n = mem_only ? !busy : !irq_req;
  assign wait_n = !(!(rd_n && wr_n) && (wcnt < wait_len));
  always @(posedge clk) begin
    wcnt <= (rd_n && wr_n) ? 8'h00 : wcnt + 8'h01;
    if (!wr_n && dout_oe) wr_word <= dout;
    // Released bus toggles every cycle
    din <= !rd_n ? rd_word : ~din;
  end
endmodule : pcss_card_model

// File: test/tb.sv
// Self-checking bench for the socket cycle engine
`timescale 1ns/1ps
module tb;
  import pcss_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, mem_only_mode = 1'b0, dma_en = 1'b0;
  logic        card_reset_req = 1'b0, req_valid = 1'b0, dma_dir = 1'b0, dma_last = 1'b0;
  logic        busy = 1'b0, irq_req = 1'b0, io_port_wide_ack_n = 1'b0;
  logic        voltage_sense_a = 1'b0, voltage_sense_b = 1'b0;
  pcss_kind_t  req_kind = K_MEM_RD;
  logic [15:0] req_wdata = 16'h0000, dma_wdata = 16'h0000, rd_word = 16'h0000;
  logic [7:0]  wait_len = 8'h00;
  logic        req_ready, resp_valid, dma_done, card_ready, card_irq, write_protect, io_wide;
  logic        dma_pending, cycle_busy, mem_read_strobe_n, mem_write_strobe_n;
  logic        io_read_strobe_n, io_write_strobe_n, attr_select_n, card_reset;
  logic        card_data_oe, card_wait_n, card_irq_n;
  logic [15:0] resp_rdata, card_data_o, card_data_i, wr_word;
  pcss_volt_t  volt_class;
  logic [4:0]  seen;
  integer      seed = 32'h2424e4f3;
  int          mismatches = 0, checks = 0, cyc_len, low_len, n;

  pcss_socket uut (
    .clk, .rst, .mem_only_mode, .dma_en, .card_reset_req, .req_valid, .req_ready, .req_kind,
    .req_wdata, .resp_valid, .resp_rdata, .dma_dir, .dma_last, .dma_wdata, .dma_done,
    .card_ready, .card_irq, .write_protect, .io_wide, .dma_pending, .volt_class, .cycle_busy,
    .mem_read_strobe_n, .mem_write_strobe_n, .io_read_strobe_n, .io_write_strobe_n,
    .attr_select_n, .card_reset, .card_data_i, .card_data_o, .card_data_oe, .card_wait_n,
    .card_irq_n, .io_port_wide_ack_n, .voltage_sense_a, .voltage_sense_b
  );
  pcss_card_model card (
    .clk, .mem_only(mem_only_mode), .rd_n(mem_read_strobe_n & io_read_strobe_n),
    .wr_n(mem_write_strobe_n & io_write_strobe_n), .dout(card_data_o),
    .dout_oe(card_data_oe), .din(card_data_i), .busy, .irq_req, .wait_len, .rd_word,
    .wr_word, .ready_irq_n(card_irq_n), .wait_n(card_wait_n)
  );

  initial forever #20 clk = ~clk;

  // Strobes seen during a cycle: {attr, io wr, io rd, mem wr, mem rd}
  always @(posedge clk) if (cycle_busy === 1'b1) begin
    cyc_len <= cyc_len + 1;
    seen <= seen | {!attr_select_n, !io_write_strobe_n, !io_read_strobe_n,
                    !mem_write_strobe_n, !mem_read_strobe_n};
    if (!(mem_read_strobe_n && mem_write_strobe_n && io_read_strobe_n && io_write_strobe_n))
      low_len <= low_len + 1;
  end

  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [4:0] exp_dma(input logic dir, input logic last);
    exp_dma = dir ? 5'h14 : 5'h18;
    if (last) exp_dma = exp_dma | (dir ? 5'h01 : 5'h02);
  endfunction : exp_dma

  function automatic logic [4:0] exp_seen(input pcss_kind_t k);
    case (k)
      K_MEM_RD: return 5'h01;
      K_MEM_WR: return 5'h02;
      K_ATT_RD: return 5'h11;
      K_ATT_WR: return 5'h12;
      K_IO_RD:  return 5'h14;
      default:  return 5'h18;
    endcase
  endfunction : exp_seen

  task automatic clear_mon();
    seen = 5'h00;
    cyc_len = 0;
    low_len = 0;
  endtask : clear_mon

  task automatic wait_resp(input logic dma);
    int k;
    k = 0;
    @(negedge clk);
    while (resp_valid !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk(resp_valid, 1'b1);
    chk(dma_done, dma);
    @(posedge clk);
    #1;
  endtask : wait_resp

  task automatic count_reset(output int c);
    c = 0;
    @(negedge clk);
    while (card_reset === 1'b1 && c < 400) begin
      c++;
      @(negedge clk);
    end
  endtask : count_reset

  task automatic host(input pcss_kind_t k, input logic [7:0] wl);
    int m;
    req_kind = k;
    req_wdata = 16'($random(seed));
    rd_word = 16'($random(seed));
    wait_len = wl;
    req_valid = 1'b1;
    m = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && m < 100) begin
      @(negedge clk);
      m++;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    clear_mon();
    wait_resp(1'b0);
    chk(seen, exp_seen(k));
    if (k inside {K_MEM_WR, K_ATT_WR, K_IO_WR}) chk(wr_word, req_wdata);
    else chk(resp_rdata, rd_word);
    if (wl == 8'h00) chk(low_len, STROBE_CYC);
    else chk(low_len > STROBE_CYC + 8, 1'b1);
    if (wl == 8'h00) chk(cyc_len, SETUP_CYC + STROBE_CYC + HOLD_CYC);
  endtask : host

  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    count_reset(n);
    chk(n >= RESET_CYC, 1'b1);
    @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++) begin
      {mem_only_mode, busy, irq_req, io_port_wide_ack_n, voltage_sense_a, voltage_sense_b}
        = 6'($random(seed));
      repeat (4) @(posedge clk);
      #1;
      chk(card_ready, mem_only_mode & !busy);
      chk(card_irq, !mem_only_mode & irq_req);
      chk(write_protect, mem_only_mode & io_port_wide_ack_n);
      chk(io_wide, !mem_only_mode & !io_port_wide_ack_n);
      chk(volt_class, {voltage_sense_b, voltage_sense_a});
    end
    {mem_only_mode, busy, io_port_wide_ack_n} = 3'b000;
    for (int i = 0; i < 12; i++) host(pcss_kind_t'(i % 6), 8'h00);
    host(K_MEM_RD, 8'h14);
    host(K_IO_WR, 8'h14);
    mem_only_mode = 1'b1;
    busy = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    req_kind = K_MEM_WR;
    req_valid = 1'b1;
    repeat (4) @(negedge clk);
    repeat (6) @(negedge clk) begin
      chk(req_ready, 1'b0);
      chk(cycle_busy, 1'b0);
    end
    @(posedge clk);
    #1 req_valid = 1'b0;
    busy = 1'b0;
    @(posedge clk);
    #1;
    host(K_MEM_WR, 8'h00);
    mem_only_mode = 1'b0;
    dma_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {dma_dir, dma_last} = 2'(i);
      dma_wdata = 16'($random(seed));
      rd_word = 16'($random(seed));
      clear_mon();
      io_port_wide_ack_n = 1'b1;
      n = 0;
      @(negedge clk);
      while (cycle_busy !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      chk(dma_pending, 1'b1);
      chk(io_wide, 1'b0);
      @(posedge clk);
      #1 io_port_wide_ack_n = 1'b0;
      wait_resp(1'b1);
      chk(seen, exp_dma(dma_dir, dma_last));
      if (dma_dir) chk(resp_rdata, rd_word);
      else chk(wr_word, dma_wdata);
    end
    dma_en = 1'b0;
    card_reset_req = 1'b1;
    @(posedge clk);
    #1 card_reset_req = 1'b0;
    count_reset(n);
    chk(n, RESET_CYC);
    end_of_test();
  end
endmodule : tb
